// ==== logic/sbld_pkg.sv ====
// Constants and types for the sensor bus and live display command block
// Function
// - Temperature setup type 0x13 carries exactly four payload bytes.
// - Each enabled sensor gets a report due flag once every second.
// - Payload forms a 32-bit mask, byte 0 bit 0 is sensor 0.
// - Temperature setup is acknowledged with type 0x53, empty payload.
// - Transaction type 0x14 takes 2 to 16 payload bytes.
// - Index 32 skips the address phase entirely.
// - Index 0-31 with known device sends Match ROM and stored address.
// - Length two means no data write phase.
// - Longer payload writes length minus two bytes after addressing.
// - Read count bytes are read into the response; zero means none.
// - Eight live slots, enabled independently, keep refreshing alone.
// - Live type 0x15: item 0 needs length 2, items 1,2 length 7.
// - Fans use 4 or 5 digits, temperatures 3 or 5 digits.
// - Last byte: fan pulses per turn 1-32, or units C/F.
// - Temperature slot shows error text on a bus CRC failure.
// - Fan slot shows slow or stop text when tach is too slow.
// - Shown fan forced full power at most 1/8 s per 1/2 s.
// - Live display command is acknowledged with 0x55, empty payload.
// - At power-up the bus ROM is read once and its address kept at index 0.
package sbld_pkg;
	localparam logic [7:0] CMD_TEMP = 8'h13;
	localparam logic [7:0] CMD_XACT = 8'h14;
	localparam logic [7:0] CMD_LIVE = 8'h15;
	localparam logic [7:0] RSP_ACK = 8'h40;
	localparam logic [7:0] RSP_ERR = 8'hc0;
	localparam logic [7:0] ROM_MATCH = 8'h55;
	localparam logic [7:0] ROM_READ = 8'h33;
	localparam logic [4:0] TEMP_LEN = 5'h04;
	localparam logic [4:0] XACT_MIN = 5'h02;
	localparam logic [4:0] XACT_MAX = 5'h10;
	localparam logic [7:0] BUS_IDX = 8'h20;
	localparam logic [7:0] RD_MAX = 8'h0e;
	localparam logic [3:0] ADDR_BYTES = 4'h9;
	localparam logic [4:0] LIVE_OFF_LEN = 5'h02;
	localparam logic [4:0] LIVE_ON_LEN = 5'h07;
	localparam logic [7:0] ITEM_OFF = 8'h00;
	localparam logic [7:0] ITEM_FAN = 8'h01;
	localparam logic [7:0] ITEM_TEMP = 8'h02;
	localparam logic [7:0] SLOTS = 8'h08;
	localparam logic [7:0] FANS = 8'h04;
	localparam logic [7:0] SENSORS = 8'h20;
	localparam logic [7:0] DIG3 = 8'h03;
	localparam logic [7:0] DIG4 = 8'h04;
	localparam logic [7:0] DIG5 = 8'h05;
	localparam logic [7:0] COL3 = 8'h0d;
	localparam logic [7:0] COL4 = 8'h0c;
	localparam logic [7:0] COL5 = 8'h0b;
	localparam logic [7:0] ROW_MAX = 8'h01;
	localparam logic [7:0] PPR_MAX = 8'h20;
	localparam logic [7:0] UNIT_MAX = 8'h01;
	localparam logic [7:0] A_CMD = 8'h00;
	localparam logic [7:0] A_PAY0 = 8'h04;
	localparam logic [7:0] A_STAT = 8'h14;
	localparam logic [7:0] A_RESP0 = 8'h18;
	localparam logic [7:0] A_MASK = 8'h28;
	localparam logic [7:0] A_DUE = 8'h2c;
	localparam logic [7:0] A_SLOT0 = 8'h30;
	localparam logic [7:0] A_SHOW = 8'h50;
	localparam int ST_BUSY = 0;
	localparam int ST_RVLD = 1;
	localparam int ST_PRES = 31;
	localparam logic [31:0] MASK_RST = 32'h0;
	localparam logic [1:0] SH_OFF = 2'h0;
	localparam logic [1:0] SH_VAL = 2'h1;
	localparam logic [1:0] SH_ERR = 2'h2;
	localparam logic [1:0] SH_SLOW = 2'h3;
	localparam int CLK_MHZ = 250;
	localparam int T_RST_NS = 480000;
	localparam int T_PRES_NS = 70000;
	localparam int T_SLOT_NS = 70000;
	localparam int T_W0_NS = 60000;
	localparam int T_W1_NS = 6000;
	localparam int T_SMP_NS = 15000;
	localparam int T_SEC_MS = 1000;
	localparam int T_WIN_MS = 500;
	localparam int T_BOOST_MS = 125;
	localparam int RST_CYC = (T_RST_NS * CLK_MHZ + 999) / 1000;
	localparam int PRES_CYC = (T_PRES_NS * CLK_MHZ + 999) / 1000;
	localparam int SLOT_CYC = (T_SLOT_NS * CLK_MHZ + 999) / 1000;
	localparam int W0_CYC = (T_W0_NS * CLK_MHZ + 999) / 1000;
	localparam int W1_CYC = (T_W1_NS * CLK_MHZ + 999) / 1000;
	localparam int SMP_CYC = (T_SMP_NS * CLK_MHZ) / 1000;
	localparam int SEC_CYC = T_SEC_MS * CLK_MHZ * 1000;
	localparam int WIN_CYC = T_WIN_MS * CLK_MHZ * 1000;
	localparam int BOOST_CYC = T_BOOST_MS * CLK_MHZ * 1000;
	typedef enum logic [1:0] {ST_IDLE, ST_RST, ST_BIT, ST_FIN} sbld_st_t;
	typedef enum logic [1:0] {PH_ADDR, PH_WR, PH_RD, PH_END} sbld_ph_t;
endpackage : sbld_pkg

// ==== logic/sbld_top.sv ====
// Command block: AHB-Lite registers, single-wire bus engine, live slots
`timescale 1ns/1ps
module sbld_top #(
	parameter int RST_C = sbld_pkg::RST_CYC, // Reset low time
	parameter int SLOT_C = sbld_pkg::SLOT_CYC, // Bit slot length
	parameter int PRES_C = SLOT_C * sbld_pkg::T_PRES_NS /
		sbld_pkg::T_SLOT_NS, // Presence sample delay
	parameter int W0_C = SLOT_C * sbld_pkg::T_W0_NS /
		sbld_pkg::T_SLOT_NS, // Write-0 low time
	parameter int W1_C = SLOT_C * sbld_pkg::T_W1_NS /
		sbld_pkg::T_SLOT_NS, // Write-1 low time
	parameter int SMP_C = SLOT_C * sbld_pkg::T_SMP_NS /
		sbld_pkg::T_SLOT_NS, // Read sample point
	parameter int SEC_C = sbld_pkg::SEC_CYC, // Report period
	parameter int WIN_C = sbld_pkg::WIN_CYC, // Boost window
	parameter int BOOST_C = sbld_pkg::BOOST_CYC // Boost length
) (
	input wire logic hclk, // Clock
	input wire logic hresetn, // Async reset, low
	input wire logic hsel, // Slave select
	input wire logic [31:0] haddr, // Address
	input wire logic [1:0] htrans, // Transfer type
	input wire logic hwrite, // Write
	input wire logic [2:0] hsize, // Size
	input wire logic [31:0] hwdata, // Write data
	input wire logic hready, // Bus ready
	output logic [31:0] hrdata, // Read data
	output logic hreadyout, // Slave ready
	output logic hresp, // Response
	input wire logic bus_in, // Single-wire bus level
	output logic bus_out, // Single-wire drive value
	output logic bus_oe, // Single-wire pull low
	input wire logic [3:0] fan_slow, // Tach below range
	input wire logic [31:0] temp_crc_err, // CRC failed per sensor
	output logic [3:0] fan_force // Fan full power
);
	sbld_pkg::sbld_st_t st_r;
	sbld_pkg::sbld_ph_t ph_r;
	logic [7:0] cmd_type_r;
	logic [4:0] cmd_len_r;
	logic start_p;
	logic [31:0] pay_r [0:3];
	logic [31:0] rx_r [0:3];
	logic [31:0] slot_r [0:7];
	logic [63:0] rom_r [0:31];
	logic [31:0] rom_vld_r;
	logic [31:0] mask_r;
	logic [31:0] due_r;
	logic [31:0] due_clr_r;
	logic [15:0] show_r;
	logic [7:0] resp_type_r;
	logic [4:0] resp_len_r;
	logic resp_vld_r;
	logic enum_pend_r;
	logic enum_r;
	logic pres_r;
	logic rbit_r;
	logic [19:0] cnt_r;
	logic [2:0] bit_r;
	logic [3:0] byte_r;
	logic [7:0] sh_r;
	logic [7:0] x_idx_r;
	logic [3:0] n_wr_r;
	logic [3:0] n_rd_r;
	logic [31:0] sec_cnt_r;
	logic sec_tick_r;
	logic [31:0] win_r;
	logic [3:0] fan_shown;
	logic busy;
	logic [31:0] rdata;
	logic [7:0] a_addr_r;
	logic a_wr_r;
	logic [31:0] pay_lo;

	assign busy = enum_pend_r || start_p || st_r != sbld_pkg::ST_IDLE;
	assign pay_lo = pay_r[0];

	function automatic logic [7:0] pay_byte(input logic [4:0] i);
		pay_byte = pay_r[i[3:2]][{i[1:0], 3'h0} +: 8];
	endfunction : pay_byte

	function automatic logic cmd_ok();
		logic [7:0] b0, b1, b2, b3, b4, b5, b6;
		logic [4:0] n;
		b0 = pay_byte(5'h00);
		b1 = pay_byte(5'h01);
		b2 = pay_byte(5'h02);
		b3 = pay_byte(5'h03);
		b4 = pay_byte(5'h04);
		b5 = pay_byte(5'h05);
		b6 = pay_byte(5'h06);
		n = cmd_len_r;
		cmd_ok = 1'b0;
		case (cmd_type_r)
		sbld_pkg::CMD_TEMP: cmd_ok = n == sbld_pkg::TEMP_LEN;
		sbld_pkg::CMD_XACT: begin
			cmd_ok = n >= sbld_pkg::XACT_MIN &&
				n <= sbld_pkg::XACT_MAX &&
				b1 <= sbld_pkg::RD_MAX &&
				(b0 == sbld_pkg::BUS_IDX ||
				(b0 < sbld_pkg::BUS_IDX && rom_vld_r[b0[4:0]]));
		end
		sbld_pkg::CMD_LIVE: begin
			if (b0 >= sbld_pkg::SLOTS)
				cmd_ok = 1'b0;
			else if (b1 == sbld_pkg::ITEM_OFF)
				cmd_ok = n == sbld_pkg::LIVE_OFF_LEN;
			else if (b1 == sbld_pkg::ITEM_FAN)
				cmd_ok = n == sbld_pkg::LIVE_ON_LEN &&
					b2 < sbld_pkg::FANS &&
					(b3 == sbld_pkg::DIG4 || b3 == sbld_pkg::DIG5) &&
					b4 <= (b3 == sbld_pkg::DIG4 ? sbld_pkg::COL4 :
					sbld_pkg::COL5) &&
					b5 <= sbld_pkg::ROW_MAX &&
					b6 != 8'h00 && b6 <= sbld_pkg::PPR_MAX;
			else if (b1 == sbld_pkg::ITEM_TEMP)
				cmd_ok = n == sbld_pkg::LIVE_ON_LEN &&
					b2 < sbld_pkg::SENSORS && rom_vld_r[b2[4:0]] &&
					(b3 == sbld_pkg::DIG3 || b3 == sbld_pkg::DIG5) &&
					b4 <= (b3 == sbld_pkg::DIG3 ? sbld_pkg::COL3 :
					sbld_pkg::COL5) &&
					b5 <= sbld_pkg::ROW_MAX &&
					b6 <= sbld_pkg::UNIT_MAX;
			else
				cmd_ok = 1'b0;
		end
		default: cmd_ok = 1'b0;
		endcase
	endfunction : cmd_ok

	// First phase at or after the given one that has bytes to move
	function automatic sbld_pkg::sbld_ph_t first_ph(
		input sbld_pkg::sbld_ph_t from);
		first_ph = sbld_pkg::PH_END;
		if (from <= sbld_pkg::PH_RD && n_rd_r != 4'h0)
			first_ph = sbld_pkg::PH_RD;
		if (from <= sbld_pkg::PH_WR && n_wr_r != 4'h0)
			first_ph = sbld_pkg::PH_WR;
		if (from == sbld_pkg::PH_ADDR && x_idx_r != sbld_pkg::BUS_IDX)
			first_ph = sbld_pkg::PH_ADDR;
	endfunction : first_ph

	function automatic logic [3:0] ph_cnt(input sbld_pkg::sbld_ph_t p);
		case (p)
		sbld_pkg::PH_ADDR: ph_cnt = sbld_pkg::ADDR_BYTES;
		sbld_pkg::PH_WR: ph_cnt = n_wr_r;
		sbld_pkg::PH_RD: ph_cnt = n_rd_r;
		default: ph_cnt = 4'h0;
		endcase
	endfunction : ph_cnt

	function automatic logic [7:0] tx_byte(input sbld_pkg::sbld_ph_t p,
		input logic [3:0] k);
		logic [2:0] j;
		j = k[2:0] - 3'h1;
		tx_byte = 8'hff;
		if (p == sbld_pkg::PH_ADDR)
			tx_byte = k == 4'h0 ? sbld_pkg::ROM_MATCH :
				rom_r[x_idx_r[4:0]][{j, 3'h0} +: 8];
		else if (p == sbld_pkg::PH_WR)
			tx_byte = enum_r ? sbld_pkg::ROM_READ :
				pay_byte({1'b0, k} + 5'h02);
	endfunction : tx_byte

	// Register read mux, sampled in the address phase
	always_comb begin
		rdata = 32'h0;
		if (haddr[31:8] == 24'h0) begin
			case (haddr[7:0])
			sbld_pkg::A_CMD: rdata = {19'h0, cmd_len_r, cmd_type_r};
			sbld_pkg::A_STAT: begin
				rdata = {8'h0, 3'h0, resp_len_r, resp_type_r, 8'h0};
				rdata[sbld_pkg::ST_BUSY] = busy;
				rdata[sbld_pkg::ST_RVLD] = resp_vld_r;
				rdata[sbld_pkg::ST_PRES] = rom_vld_r[0];
			end
			sbld_pkg::A_MASK: rdata = mask_r;
			sbld_pkg::A_DUE: rdata = due_r;
			sbld_pkg::A_SHOW: rdata = {16'h0, show_r};
			default: begin
				if (haddr[7:0] >= sbld_pkg::A_SLOT0 &&
					haddr[7:0] < sbld_pkg::A_SHOW)
					rdata = slot_r[3'(haddr[7:2] - sbld_pkg::A_SLOT0[7:2])];
				else if (haddr[7:0] >= sbld_pkg::A_RESP0 &&
					haddr[7:0] < sbld_pkg::A_MASK)
					rdata = rx_r[haddr[3:2] - 2'h2];
				else if (haddr[7:0] >= sbld_pkg::A_PAY0 &&
					haddr[7:0] < sbld_pkg::A_STAT)
					rdata = pay_r[haddr[3:2] - 2'h1];
			end
			endcase
		end
	end

	// AHB-Lite slave, zero wait states, always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			a_wr_r <= 1'b0;
			a_addr_r <= 8'h0;
			start_p <= 1'b0;
			cmd_type_r <= 8'h0;
			cmd_len_r <= 5'h0;
			due_clr_r <= 32'h0;
			for (int i = 0; i < 4; i++)
				pay_r[i] <= 32'h0;
		end else begin
			start_p <= 1'b0;
			due_clr_r <= 32'h0;
			a_wr_r <= 1'b0;
			if (hsel && htrans[1] && hready) begin
				a_wr_r <= hwrite && haddr[31:8] == 24'h0;
				a_addr_r <= haddr[7:0];
				if (!hwrite)
					hrdata <= rdata;
			end
			if (a_wr_r) begin
				if (a_addr_r == sbld_pkg::A_CMD && !busy) begin
					cmd_type_r <= hwdata[7:0];
					cmd_len_r <= hwdata[12:8];
					start_p <= 1'b1;
				end
				if (a_addr_r == sbld_pkg::A_DUE)
					due_clr_r <= hwdata;
				if (a_addr_r >= sbld_pkg::A_PAY0 &&
					a_addr_r < sbld_pkg::A_STAT && !busy)
					pay_r[a_addr_r[3:2] - 2'h1] <= hwdata;
			end
		end
	end

	// Command decode and single-wire bus engine
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r <= sbld_pkg::ST_IDLE;
			ph_r <= sbld_pkg::PH_ADDR;
			enum_pend_r <= 1'b1;
			enum_r <= 1'b0;
			pres_r <= 1'b0;
			rbit_r <= 1'b1;
			cnt_r <= 20'h0;
			bit_r <= 3'h0;
			byte_r <= 4'h0;
			sh_r <= 8'h0;
			x_idx_r <= 8'h0;
			n_wr_r <= 4'h0;
			n_rd_r <= 4'h0;
			bus_oe <= 1'b0;
			bus_out <= 1'b0;
			mask_r <= sbld_pkg::MASK_RST;
			resp_type_r <= 8'h0;
			resp_len_r <= 5'h0;
			resp_vld_r <= 1'b0;
			rom_vld_r <= 32'h0;
			for (int i = 0; i < 4; i++)
				rx_r[i] <= 32'h0;
			for (int i = 0; i < 8; i++)
				slot_r[i] <= 32'h0;
			for (int i = 0; i < 32; i++)
				rom_r[i] <= 64'h0;
		end else begin
			case (st_r)
			sbld_pkg::ST_IDLE: begin
				bus_oe <= 1'b0;
				if (enum_pend_r) begin
					// Power-up: reset, read ROM into index 0
					enum_pend_r <= 1'b0;
					enum_r <= 1'b1;
					x_idx_r <= sbld_pkg::BUS_IDX;
					n_wr_r <= 4'h1;
					n_rd_r <= 4'h8;
					cnt_r <= 20'h0;
					st_r <= sbld_pkg::ST_RST;
				end else if (start_p) begin
					resp_vld_r <= 1'b1;
					resp_len_r <= 5'h0;
					resp_type_r <= sbld_pkg::RSP_ACK | cmd_type_r;
					if (!cmd_ok())
						resp_type_r <= sbld_pkg::RSP_ERR | cmd_type_r;
					else if (cmd_type_r == sbld_pkg::CMD_TEMP)
						mask_r <= pay_r[0];
					else if (cmd_type_r == sbld_pkg::CMD_LIVE)
						slot_r[pay_r[0][2:0]] <=
							pay_byte(5'h01) == sbld_pkg::ITEM_OFF ? 32'h0 :
							{11'h0, 6'(pay_byte(5'h06)), 1'(pay_byte(5'h05)),
							4'(pay_byte(5'h04)), 3'(pay_byte(5'h03)),
							5'(pay_byte(5'h02)), 2'(pay_byte(5'h01))};
					else begin
						resp_vld_r <= 1'b0;
						enum_r <= 1'b0;
						x_idx_r <= pay_byte(5'h00);
						n_wr_r <= 4'(cmd_len_r - sbld_pkg::XACT_MIN);
						n_rd_r <= 4'(pay_byte(5'h01));
						cnt_r <= 20'h0;
						st_r <= sbld_pkg::ST_RST;
					end
				end
			end
			sbld_pkg::ST_RST: begin
				cnt_r <= cnt_r + 20'h1;
				bus_oe <= cnt_r < RST_C;
				if (cnt_r == 20'(RST_C + PRES_C))
					pres_r <= ~bus_in;
				if (cnt_r == 20'(2 * RST_C - 1)) begin
					cnt_r <= 20'h0;
					bit_r <= 3'h0;
					byte_r <= 4'h0;
					ph_r <= first_ph(sbld_pkg::PH_ADDR);
					sh_r <= tx_byte(first_ph(sbld_pkg::PH_ADDR), 4'h0);
					st_r <= first_ph(sbld_pkg::PH_ADDR) == sbld_pkg::PH_END ?
						sbld_pkg::ST_FIN : sbld_pkg::ST_BIT;
				end
			end
			sbld_pkg::ST_BIT: begin
				cnt_r <= cnt_r + 20'h1;
				bus_oe <= cnt_r < (sh_r[0] ? W1_C : W0_C);
				if (cnt_r == 20'(SMP_C))
					rbit_r <= bus_in;
				if (cnt_r == 20'(SLOT_C - 1)) begin
					cnt_r <= 20'h0;
					bit_r <= bit_r + 3'h1;
					sh_r <= {rbit_r, sh_r[7:1]};
					if (bit_r == 3'h7) begin
						if (ph_r == sbld_pkg::PH_RD)
							rx_r[byte_r[3:2]][{byte_r[1:0], 3'h0} +: 8] <=
								{rbit_r, sh_r[7:1]};
						if (byte_r + 4'h1 == ph_cnt(ph_r)) begin
							byte_r <= 4'h0;
							ph_r <= first_ph(ph_r == sbld_pkg::PH_ADDR ?
								sbld_pkg::PH_WR : (ph_r == sbld_pkg::PH_WR ?
								sbld_pkg::PH_RD : sbld_pkg::PH_END));
							sh_r <= tx_byte(first_ph(
								ph_r == sbld_pkg::PH_ADDR ?
								sbld_pkg::PH_WR : sbld_pkg::PH_RD), 4'h0);
							if (ph_r == sbld_pkg::PH_RD ||
								first_ph(ph_r == sbld_pkg::PH_ADDR ?
								sbld_pkg::PH_WR : sbld_pkg::PH_RD) ==
								sbld_pkg::PH_END)
								st_r <= sbld_pkg::ST_FIN;
						end else begin
							byte_r <= byte_r + 4'h1;
							sh_r <= tx_byte(ph_r, byte_r + 4'h1);
						end
					end
				end
			end
			sbld_pkg::ST_FIN: begin
				bus_oe <= 1'b0;
				st_r <= sbld_pkg::ST_IDLE;
				if (enum_r) begin
					rom_r[0] <= {rx_r[1], rx_r[0]};
					rom_vld_r[0] <= pres_r;
				end else begin
					resp_type_r <= sbld_pkg::RSP_ACK | sbld_pkg::CMD_XACT;
					resp_len_r <= {1'b0, n_rd_r};
					resp_vld_r <= 1'b1;
				end
			end
			default: st_r <= sbld_pkg::ST_IDLE;
			endcase
		end
	end

	// One-second report ticks; a new tick wins over a clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sec_cnt_r <= 32'h0;
			sec_tick_r <= 1'b0;
			due_r <= 32'h0;
		end else begin
			sec_tick_r <= sec_cnt_r == 32'(SEC_C - 1);
			sec_cnt_r <= sec_cnt_r == 32'(SEC_C - 1) ? 32'h0 :
				sec_cnt_r + 32'h1;
			due_r <= (due_r & ~due_clr_r) |
				(sec_tick_r ? mask_r : 32'h0);
		end
	end

	always_comb begin
		fan_shown = 4'h0;
		for (int s = 0; s < 8; s++)
			if (slot_r[s][1:0] == sbld_pkg::ITEM_FAN[1:0])
				fan_shown[slot_r[s][3:2]] = 1'b1;
	end

	// Slot display codes and fan boost window
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			win_r <= 32'h0;
			fan_force <= 4'h0;
			show_r <= 16'h0;
		end else begin
			win_r <= win_r == 32'(WIN_C - 1) ? 32'h0 : win_r + 32'h1;
			fan_force <= win_r < 32'(BOOST_C) ? fan_shown : 4'h0;
			for (int s = 0; s < 8; s++) begin
				case (slot_r[s][1:0])
				sbld_pkg::ITEM_FAN[1:0]: show_r[2*s +: 2] <=
					fan_slow[slot_r[s][3:2]] ? sbld_pkg::SH_SLOW :
					sbld_pkg::SH_VAL;
				sbld_pkg::ITEM_TEMP[1:0]: show_r[2*s +: 2] <=
					temp_crc_err[slot_r[s][6:2]] ? sbld_pkg::SH_ERR :
					sbld_pkg::SH_VAL;
				default: show_r[2*s +: 2] <= sbld_pkg::SH_OFF;
				endcase
			end
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_mask_load: assert property (start_p && st_r == sbld_pkg::ST_IDLE &&
		!enum_pend_r && cmd_type_r == sbld_pkg::CMD_TEMP &&
		cmd_len_r == sbld_pkg::TEMP_LEN |=> mask_r == $past(pay_lo))
		else $error("mask not loaded");
	a_temp_ack: assert property (start_p && !enum_pend_r &&
		st_r == sbld_pkg::ST_IDLE && cmd_type_r == sbld_pkg::CMD_TEMP &&
		cmd_len_r == sbld_pkg::TEMP_LEN |=> resp_vld_r &&
		resp_type_r == 8'h53 && resp_len_r == 5'h0)
		else $error("bad temperature ack");
	a_bad_reject: assert property (start_p && !enum_pend_r &&
		st_r == sbld_pkg::ST_IDLE && cmd_type_r == sbld_pkg::CMD_LIVE &&
		cmd_len_r != sbld_pkg::LIVE_OFF_LEN &&
		cmd_len_r != sbld_pkg::LIVE_ON_LEN |=> resp_type_r == 8'hd5)
		else $error("bad length accepted");
	a_skip_addr: assert property (ph_r == sbld_pkg::PH_ADDR &&
		st_r == sbld_pkg::ST_BIT |-> x_idx_r != sbld_pkg::BUS_IDX)
		else $error("address phase at index 32");
	a_no_write: assert property (ph_r == sbld_pkg::PH_WR &&
		st_r == sbld_pkg::ST_BIT |-> n_wr_r != 4'h0)
		else $error("write phase with no bytes");
	a_boost_limit: assert property (fan_force != 4'h0 |->
		win_r <= 32'(BOOST_C))
		else $error("boost beyond window");
	a_due_set: assert property (sec_tick_r |=>
		(due_r & $past(mask_r)) == $past(mask_r))
		else $error("report not flagged");
	a_xact_len: assert property (st_r == sbld_pkg::ST_FIN && !enum_r
		|=> resp_len_r == {1'b0, $past(n_rd_r)} && resp_vld_r)
		else $error("read length wrong");
	a_match_rom: assert property ($rose(st_r == sbld_pkg::ST_BIT) &&
		ph_r == sbld_pkg::PH_ADDR |-> sh_r == sbld_pkg::ROM_MATCH)
		else $error("address phase without match");
	c_xact: cover property (st_r == sbld_pkg::ST_FIN && !enum_r);
	c_boost: cover property (fan_force != 4'h0);
	c_reject: cover property (start_p ##1 resp_type_r[7:6] == 2'h3);
	c_tick: cover property (sec_tick_r && mask_r != 32'h0);
endmodule : sbld_top

// ==== tb/sbld_bus_model.sv ====
// Single-wire bus device model: presence, slot capture, read data
`timescale 1ns/1ps
module sbld_bus_model (
	input wire logic clk, // Clock
	input wire logic rst_n, // Reset, low
	input wire logic bus_low, // Master pulling low
	input wire logic present, // Answer bus resets
	input wire logic [7:0] wr_slots, // Slots before read data
	input wire logic [63:0] rd_data, // Read bits, LSB first
	output logic pull, // Model pulling low
	output logic [255:0] wbits, // Slot bits seen
	output logic [7:0] nslot // Slots since bus reset
);
	int low_c;
	int hold_c;
	logic rd_zero;
	assign pull = hold_c != 0;
	assign rd_zero = nslot >= wr_slots && !rd_data[6'(nslot - wr_slots)];
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			low_c <= 0;
			hold_c <= 0;
			wbits <= '0;
			nslot <= 8'h00;
		end else begin
			low_c <= bus_low ? low_c + 1 : 0;
			if (hold_c != 0) begin
				hold_c <= hold_c - 1;
			end
			if (bus_low && low_c == 0 && rd_zero) begin
				hold_c <= 10;
			end
			if (!bus_low && low_c > 30) begin
				hold_c <= present ? 25 : 0;
				nslot <= 8'h00;
			end else if (!bus_low && low_c != 0) begin
				wbits[nslot] <= low_c < 8;
				nslot <= nslot + 8'h01;
			end
		end
	end
endmodule : sbld_bus_model

// ==== tb/sbld_top_tb_top.sv ====
// Self-checking bench for the sensor bus and live display command block
`timescale 1ns/1ps
`define CHK(g, e) check(80'(g), 80'(e))
module sbld_top_tb_top;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic bus_in, bus_out, bus_oe, pull, present;
	logic [31:0] haddr, hwdata, hrdata, temp_crc_err, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [3:0] fan_slow, fan_force;
	logic [7:0] wr_slots, nslot;
	logic [63:0] rd_data;
	logic [255:0] wbits;
	int error_cnt, total_checks;
	localparam logic [63:0] ROM = 64'h6b00_0000_1234_5628;
	logic [76:0] bad [12] = '{
		{13'h1114, 32'h20, 32'h0}, {13'h0114, 32'h20, 32'h0},
		{13'h0214, 32'h21, 32'h0}, {13'h0214, 32'h0f20, 32'h0},
		{13'h0214, 32'h05, 32'h0}, {13'h0513, 32'h0, 32'h0},
		{13'h0715, 32'h04010100, 32'h0001000d},
		{13'h0715, 32'h04040100, 32'h0020000c},
		{13'h0715, 32'h04010100, 32'h0000000c},
		{13'h0715, 32'h03000200, 32'h00000200},
		{13'h0715, 32'h04010108, 32'h0020010c},
		{13'h0715, 32'h0, 32'h0}};
	assign hready = hreadyout;
	assign bus_in = !(bus_oe || pull);
	sbld_top #(.RST_C(40), .SLOT_C(20), .SEC_C(200), .WIN_C(64),
		.BOOST_C(16)) u_sbld_top (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .bus_in(bus_in), .bus_out(bus_out), .bus_oe(bus_oe),
		.fan_slow(fan_slow), .temp_crc_err(temp_crc_err),
		.fan_force(fan_force));
	sbld_bus_model u_sbld_bus_model (.clk(hclk), .rst_n(hresetn),
		.bus_low(bus_oe), .present(present), .wr_slots(wr_slots),
		.rd_data(rd_data), .pull(pull), .wbits(wbits), .nslot(nslot));
	initial begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end
	task automatic check(input logic [79:0] g, input logic [79:0] e);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR at %0t: got %h expected %h", $time, g, e);
		end
	endtask : check
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask : bus
	task automatic poll(input logic v);
		do bus(1'b0, 8'h14, 32'h0);
		while (rd[0] !== 1'b0 || (v && rd[1] !== 1'b1));
	endtask : poll
	task automatic cmd(input logic [12:0] tl, input logic [31:0] w0, w1);
		bus(1'b1, 8'h04, w0);
		bus(1'b1, 8'h08, w1);
		bus(1'b1, 8'h00, {19'h0, tl});
		repeat (3) @(posedge hclk);
		poll(1'b1);
	endtask : cmd
	task automatic boost(input int e0, e1);
		int n0, n1;
		n0 = 0;
		n1 = 0;
		repeat (128) begin
			@(posedge hclk);
			n0 += int'(fan_force[0] === 1'b1);
			n1 += int'(fan_force[1] === 1'b1);
		end
		`CHK(n0, e0);
		`CHK(n1, e1);
	endtask : boost
	task automatic t_reset;
		bus(1'b0, 8'h30, 32'h0);
		`CHK(rd, 32'h0);
		bus(1'b1, 8'h80, 32'hffff_ffff);
		bus(1'b0, 8'h80, 32'h0);
		`CHK(rd, 32'h0);
		poll(1'b0);
		`CHK(rd[31], 1'b1);
		`CHK({hresp, hreadyout, bus_out}, 3'h2);
		$display("reset test done");
	endtask : t_reset
	task automatic t_temp;
		repeat (210) @(posedge hclk);
		bus(1'b0, 8'h2c, 32'h0);
		`CHK(rd, 32'h0);
		cmd(13'h0413, 32'h1, 32'h0);
		`CHK(rd[20:8], 13'h0053);
		bus(1'b0, 8'h28, 32'h0);
		`CHK(rd, 32'h1);
		repeat (205) @(posedge hclk);
		bus(1'b0, 8'h2c, 32'h0);
		`CHK(rd, 32'h1);
		$display("temperature test done");
	endtask : t_temp
	task automatic t_xact;
		wr_slots <= 8'd16;
		rd_data <= 64'hbeef;
		cmd(13'h0414, 32'h3ca5_0220, 32'h0);
		`CHK(rd[20:8], 13'h0254);
		`CHK(wbits[15:0], 16'h3ca5);
		`CHK(nslot, 8'd32);
		bus(1'b0, 8'h18, 32'h0);
		`CHK(rd[15:0], 16'hbeef);
		cmd(13'h0214, 32'h20, 32'h0);
		`CHK(nslot, 8'd0);
		wr_slots <= 8'd80;
		cmd(13'h0314, 32'h0044_0000, 32'h0);
		`CHK(rd[20:8], 13'h0054);
		`CHK(wbits[79:0], {8'h44, ROM, 8'h55});
		`CHK(nslot, 8'd80);
		wr_slots <= 8'd72;
		rd_data <= 64'h5a;
		cmd(13'h0214, 32'h0000_0100, 32'h0);
		`CHK(rd[20:8], 13'h0154);
		bus(1'b0, 8'h18, 32'h0);
		`CHK(rd[7:0], 8'h5a);
		$display("transaction test done");
	endtask : t_xact
	task automatic t_err;
		foreach (bad[i]) begin
			cmd(bad[i][76:64], bad[i][63:32], bad[i][31:0]);
			`CHK(rd[20:8], {5'h00, 8'hc0 | bad[i][71:64]});
		end
		$display("error test done");
	endtask : t_err
	task automatic t_live;
		cmd(13'h0715, 32'h0401_0100, 32'h0020_010c);
		`CHK(rd[20:8], 13'h0055);
		cmd(13'h0715, 32'h0500_0201, 32'h0001_000b);
		`CHK(rd[20:8], 13'h0055);
		bus(1'b0, 8'h30, 32'h0);
		`CHK(rd, 32'h0010_7205);
		bus(1'b0, 8'h34, 32'h0);
		`CHK(rd, 32'h0000_ae82);
		bus(1'b0, 8'h50, 32'h0);
		`CHK(rd[3:0], 4'h5);
		boost(0, 32);
		fan_slow <= 4'h2;
		temp_crc_err <= 32'h1;
		repeat (4) @(posedge hclk);
		bus(1'b0, 8'h50, 32'h0);
		`CHK(rd[3:0], 4'hb);
		cmd(13'h0215, 32'h0, 32'h0);
		`CHK(rd[20:8], 13'h0055);
		bus(1'b0, 8'h30, 32'h0);
		`CHK(rd, 32'h0);
		boost(0, 0);
		$display("live display test done");
	endtask : t_live
	task automatic results;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : results
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		hwrite = 1'b0;
		haddr = 32'h0;
		hwdata = 32'h0;
		htrans = 2'h0;
		hsize = 3'h2;
		fan_slow = 4'h0;
		temp_crc_err = 32'h0;
		present = 1'b1;
		wr_slots = 8'd8;
		rd_data = ROM;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset;
		t_temp;
		t_xact;
		t_err;
		t_live;
		results;
	end
	initial begin
		#200000;
		error_cnt++;
		results;
	end
endmodule : sbld_top_tb_top
